/* File: shared/io_port_pkg.sv */
package io_port_pkg;

    // ==========================================================
    // Port addresses, low address byte
    localparam logic [7:0] PORT_DISPLAY    = 8'hff;
    localparam logic [7:0] PORT_KEYTAPE    = 8'hfe;
    localparam logic [7:0] PORT_RSVD_FD    = 8'hfd;
    localparam logic [7:0] PORT_RSVD_FC    = 8'hfc;
    localparam logic [7:0] PORT_PRINTER    = 8'hfb;
    localparam logic [7:0] PORT_SOUND_DATA = 8'hf6;
    localparam logic [7:0] PORT_SOUND_ADDR = 8'hf5;
    localparam logic [7:0] PORT_BANK       = 8'hf4;

    // ==========================================================
    // Printer decode and bit positions
    localparam int PRN_ONE_BIT       = 7;
    localparam int PRN_ZERO_BIT      = 2;
    localparam int PRN_RD_READY_BIT  = 0;
    localparam int PRN_RD_NOCFG_BIT  = 6;
    localparam int PRN_RD_START_BIT  = 7;
    localparam int PRN_WR_SLOW_BIT   = 1;
    localparam int PRN_WR_OFF_BIT    = 2;
    localparam int PRN_WR_PIXEL_BIT  = 7;

    // ==========================================================
    // Keyboard/tape read layout
    localparam int KT_COLS           = 5;
    localparam int KT_ROWS           = 8;
    localparam int KT_UNUSED_BIT     = 5;
    localparam int KT_TAPE_IN_BIT    = 6;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DISPLAY_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET    = 8'h00;
    localparam logic [7:0] KEYTAPE_RESET = 8'h00;
    localparam logic [7:0] SOUND_RESET   = 8'h00;
    localparam logic [7:0] PRINTER_RESET = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ            = 20;
    localparam int FRAME_PERIOD_NS    = 16635000;
    localparam int FRAME_PERIOD_CYCLES =
        FRAME_PERIOD_NS * CLK_MHZ / 1000;
    localparam int IRQ_PULSE_NS       = 8000;
    localparam int IRQ_PULSE_CYCLES   = IRQ_PULSE_NS * CLK_MHZ / 1000;
    localparam int FRAME_CNT_W        = 19;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        VM_NORMAL = 3'b000,
        VM_SECOND = 3'b001,
        VM_HIRES  = 3'b010,
        VM_COL64  = 3'b110
    } video_mode_t;

    typedef enum logic [2:0] {
        COL_BLACK = 3'b000, COL_BLUE  = 3'b001,
        COL_RED   = 3'b010, COL_MAGENTA = 3'b011,
        COL_GREEN = 3'b100, COL_CYAN  = 3'b101,
        COL_YELLOW = 3'b110, COL_WHITE = 3'b111
    } colour_t;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic       exromSel;
        logic       irqInhibit;
        logic [2:0] inkPaper;
        logic [2:0] videoMode;
    } display_ctrl_t;

    typedef struct packed {
        logic [2:0] unused;
        logic       beep;
        logic       tapeOut;
        colour_t    border;
    } keytape_out_t;

    typedef struct packed {
        logic notConfigured;
        logic readyForPixel;
        logic startOfPaper;
    } printer_status_t;

endpackage : io_port_pkg

/* File: core/io_port_regs.sv */
`timescale 1ns/100ps
// Overview of operation
// - Full 8-bit decode: FF, FE, F6, F5, F4; FD and FC reserved.
// - Video mode: 000 normal, 001 second file, 010 hi-res, 110 64-col.
// - Ink/paper pair for 64-column mode, 000 black/white to 111.
// - Display bit gates frame interrupt: 0 enables, 1 inhibits.
// - Display bit picks extension ROM or cartridge bank for chunks.
// - Port FE writes border, tape out, beep; reads keys and tape.
// - Border colour codes 000 black through 111 white.
// - Port FE read gives five key columns low; unused bit reads 0.
// - Port FE read shows current tape input level in its own bit.
// - Printer answers when address bit 7 is 1 and bit 2 is 0.
// - Printer status: not configured, ready for pixel, start of paper.
// - F5 write-only sound address; F6 sound data and joystick.
// - Set bank bit enables its 8K chunk in cartridge or extension bank.
// - Frame interrupt inhibit sits in display control bit 6.
// - Frame interrupt raised each vertical blank, every 16.635 ms.
// - High address bits pick key rows; pressed key reads 0.
module io_port_regs
    import io_port_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_PERIOD_CYCLES
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // Processor I/O cycle
    input  wire logic [15:0]     cpuAddr,
    input  wire logic [7:0]      cpuDataIn,
    output logic      [7:0]      cpuDataOut,
    output logic                 cpuDataOe,
    input  wire logic            ioReqN,
    input  wire logic            rdN,
    input  wire logic            wrN,
    output logic                 frameIrqN,
    // Keyboard and tape
    input  wire logic [39:0]     keyPressed,
    input  wire logic            tapeIn,
    output colour_t              borderColour,
    output logic                 tapeOut,
    output logic                 beepOut,
    // Display and banking
    output display_ctrl_t        displayCtrl,
    output logic      [7:0]      bankChunkSelect,
    output logic      [7:0]      dockChunkEn,
    output logic      [7:0]      exromChunkEn,
    // Sound generator
    output logic      [7:0]      soundAddr,
    output logic      [7:0]      soundWrData,
    output logic                 soundWrStb,
    output logic                 soundRdStb,
    input  wire logic [7:0]      soundRdData,
    // Printer
    output logic                 printerWrStb,
    output logic                 printerRdStb,
    output logic                 printerSlow,
    output logic                 printerMotorOff,
    output logic                 printerPixel,
    input  wire printer_status_t printerStatus
);

    // ==========================================================
    // Helpers
    function automatic logic [KT_COLS-1:0] keyColumns(
        input logic [39:0] keys,
        input logic [7:0]  rowSelN
    );
        logic [KT_COLS-1:0] cols;
        cols = '1;
        for (int r = 0; r < KT_ROWS; r++) begin
            for (int c = 0; c < KT_COLS; c++) begin
                if (!rowSelN[r] && keys[r*KT_COLS+c]) begin
                    cols[c] = 1'b0;
                end
            end
        end
        return cols;
    endfunction : keyColumns

    function automatic logic isPrinter(input logic [7:0] a);
        return a[PRN_ONE_BIT] && !a[PRN_ZERO_BIT];
    endfunction : isPrinter

    // ==========================================================
    // Input synchronisers
    // Address and data share the strobes' two stages, so
    // they have settled once a strobe is seen.
    logic [15:0]     addrMeta_q;
    logic [15:0]     addr_q;
    logic [7:0]      dataMeta_q;
    logic [7:0]      data_q;
    logic [2:0]      strbMeta_q;
    logic [2:0]      strb_q;
    logic [39:0]     keyMeta_q;
    logic [39:0]     key_q;
    logic            tapeMeta_q;
    logic            tape_q;
    logic [7:0]      sndMeta_q;
    logic [7:0]      snd_q;
    printer_status_t prnMeta_q;
    printer_status_t prn_q;

    always_ff @(posedge mclk) begin
        addrMeta_q <= cpuAddr;
        addr_q     <= addrMeta_q;
        dataMeta_q <= cpuDataIn;
        data_q     <= dataMeta_q;
        keyMeta_q  <= keyPressed;
        key_q      <= keyMeta_q;
        tapeMeta_q <= tapeIn;
        tape_q     <= tapeMeta_q;
        sndMeta_q  <= soundRdData;
        snd_q      <= sndMeta_q;
        prnMeta_q  <= printerStatus;
        prn_q      <= prnMeta_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            strbMeta_q <= 3'b111;
            strb_q     <= 3'b111;
        end else begin
            strbMeta_q <= {ioReqN, rdN, wrN};
            strb_q     <= strbMeta_q;
        end
    end

    // ==========================================================
    // Cycle decode
    logic       ioRd;
    logic       ioWr;
    logic [7:0] port;
    logic       selDisplay;
    logic       selKeyTape;
    logic       selSndData;
    logic       selSndAddr;
    logic       selBank;
    logic       selPrinter;
    logic       readMapped;

    assign ioRd = !strb_q[2] && !strb_q[1];
    assign ioWr = !strb_q[2] && !strb_q[0];
    assign port = addr_q[7:0];

    // FD and FC select nothing
    assign selDisplay = (port == PORT_DISPLAY);
    assign selKeyTape = (port == PORT_KEYTAPE);
    assign selSndData = (port == PORT_SOUND_DATA);
    assign selSndAddr = (port == PORT_SOUND_ADDR);
    assign selBank    = (port == PORT_BANK);
    assign selPrinter = isPrinter(port);
    // F5 is write-only
    assign readMapped = selDisplay || selKeyTape || selSndData
                     || selBank || selPrinter;

    // ==========================================================
    // Bus cycle tracking
    bus_state_t state_q;
    logic       wrStart;
    logic       rdStart;

    assign wrStart = (state_q == BUS_IDLE) && ioWr;
    assign rdStart = (state_q == BUS_IDLE) && !ioWr && ioRd;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= BUS_IDLE;
        end else begin
            case (state_q)
                BUS_IDLE: begin
                    if (ioWr) begin
                        state_q <= BUS_WRITE;
                    end else if (ioRd) begin
                        state_q <= BUS_READ;
                    end
                end
                BUS_WRITE: begin
                    if (!ioWr) begin
                        state_q <= BUS_IDLE;
                    end
                end
                BUS_READ: begin
                    if (!ioRd) begin
                        state_q <= BUS_IDLE;
                    end
                end
                default: begin
                    state_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Display control and bank select
    display_ctrl_t display_q;
    logic [7:0]    bank_q;
    logic [7:0]    dock_q;
    logic [7:0]    extension_rom_select_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            display_q <= display_ctrl_t'(DISPLAY_RESET);
        end else if (wrStart && selDisplay) begin
            // Mode, ink/paper, inhibit (bit 6), bank source (bit 7)
            display_q <= display_ctrl_t'(data_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_q <= BANK_RESET;
        end else if (wrStart && selBank) begin
            bank_q <= data_q;
        end
    end

    // Chunks clear in both enables fall back to home
    always_ff @(posedge mclk) begin
        if (rst) begin
            dock_q  <= BANK_RESET;
            extension_rom_select_q <= BANK_RESET;
        end else begin
            dock_q  <= display_q.exromSel ? 8'h00 : bank_q;
            extension_rom_select_q <= display_q.exromSel ? bank_q : 8'h00;
        end
    end

    // ==========================================================
    // Keyboard/tape outputs
    keytape_out_t keyTapeOut_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            keyTapeOut_q <= keytape_out_t'(KEYTAPE_RESET);
        end else if (wrStart && selKeyTape) begin
            keyTapeOut_q <= keytape_out_t'(data_q);
        end
    end

    // ==========================================================
    // Sound generator access
    logic [7:0] sndAddr_q;
    logic [7:0] sndWrData_q;
    logic       sndWrStb_q;
    logic       sndRdStb_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sndAddr_q   <= SOUND_RESET;
            sndWrData_q <= SOUND_RESET;
            sndWrStb_q  <= 1'b0;
            sndRdStb_q  <= 1'b0;
        end else begin
            sndWrStb_q <= wrStart && selSndData;
            sndRdStb_q <= rdStart && selSndData;
            if (wrStart && selSndAddr) begin
                sndAddr_q <= data_q;
            end
            if (wrStart && selSndData) begin
                sndWrData_q <= data_q;
            end
        end
    end

    // ==========================================================
    // Printer access
    logic prnWrStb_q;
    logic prnRdStb_q;
    logic prnSlow_q;
    logic prnOff_q;
    logic prnPixel_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            prnWrStb_q <= 1'b0;
            prnRdStb_q <= 1'b0;
            prnSlow_q  <= PRINTER_RESET[PRN_WR_SLOW_BIT];
            prnOff_q   <= PRINTER_RESET[PRN_WR_OFF_BIT];
            prnPixel_q <= PRINTER_RESET[PRN_WR_PIXEL_BIT];
        end else begin
            prnWrStb_q <= wrStart && selPrinter;
            prnRdStb_q <= rdStart && selPrinter;
            if (wrStart && selPrinter) begin
                prnSlow_q  <= data_q[PRN_WR_SLOW_BIT];
                prnOff_q   <= data_q[PRN_WR_OFF_BIT];
                prnPixel_q <= data_q[PRN_WR_PIXEL_BIT];
            end
        end
    end

    // ==========================================================
    // Read data path
    logic [7:0] rdMux;
    logic [7:0] dataOut_q;
    logic       dataOe_q;

    always_comb begin
        rdMux = 8'h00;
        if (selDisplay) begin
            rdMux = display_q;
        end else if (selBank) begin
            rdMux = bank_q;
        end else if (selSndData) begin
            // Joystick data shares the sound port
            rdMux = snd_q;
        end else if (selKeyTape) begin
            rdMux[KT_COLS-1:0] = keyColumns(key_q, addr_q[15:8]);
            rdMux[KT_UNUSED_BIT]  = 1'b0;
            rdMux[KT_TAPE_IN_BIT] = tape_q;
        end else if (selPrinter) begin
            rdMux[PRN_RD_NOCFG_BIT] = prn_q.notConfigured;
            rdMux[PRN_RD_READY_BIT] = prn_q.readyForPixel;
            rdMux[PRN_RD_START_BIT] = prn_q.startOfPaper;
        end
    end

    // Data tracks inputs through the read so late key or
    // tape changes still reach the processor
    always_ff @(posedge mclk) begin
        if (rst) begin
            dataOut_q <= 8'h00;
            dataOe_q  <= 1'b0;
        end else begin
            dataOe_q  <= ioRd && !ioWr && readMapped;
            dataOut_q <= rdMux;
        end
    end

    // ==========================================================
    // Frame interrupt
    // Short pulse at the start of each frame; the processor
    // samples it, so no sticky flag is needed.
    logic [FRAME_CNT_W-1:0] frameCnt_q;
    logic                   irqN_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            frameCnt_q <= '0;
        end else if (frameCnt_q ==
                     FRAME_CNT_W'(FRAME_CYCLES - 1)) begin
            frameCnt_q <= '0;
        end else begin
            frameCnt_q <= frameCnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqN_q <= 1'b1;
        end else begin
            irqN_q <= !((frameCnt_q < FRAME_CNT_W'(IRQ_PULSE_CYCLES))
                        && !display_q.irqInhibit);
        end
    end

    // ==========================================================
    // Outputs
    assign cpuDataOut      = dataOut_q;
    assign cpuDataOe       = dataOe_q;
    assign frameIrqN       = irqN_q;
    assign borderColour    = keyTapeOut_q.border;
    assign tapeOut         = keyTapeOut_q.tapeOut;
    assign beepOut         = keyTapeOut_q.beep;
    assign displayCtrl     = display_q;
    assign bankChunkSelect = bank_q;
    assign dockChunkEn     = dock_q;
    assign exromChunkEn    = extension_rom_select_q;
    assign soundAddr       = sndAddr_q;
    assign soundWrData     = sndWrData_q;
    assign soundWrStb      = sndWrStb_q;
    assign soundRdStb      = sndRdStb_q;
    assign printerWrStb    = prnWrStb_q;
    assign printerRdStb    = prnRdStb_q;
    assign printerSlow     = prnSlow_q;
    assign printerMotorOff = prnOff_q;
    assign printerPixel    = prnPixel_q;

endmodule : io_port_regs

/* File: dv/io_port_regs_assertions.sv */
`timescale 1ns/100ps
module io_port_regs_checker
    import io_port_pkg::*;
#(
    parameter int FRAME_CYCLES = 400
) (
    // Clock and reset
    input wire logic          mclk,
    input wire logic          rst,
    // Watched ports
    input wire logic          rdN,
    input wire logic          cpuDataOe,
    input wire logic          frameIrqN,
    input wire display_ctrl_t displayCtrl,
    input wire logic [7:0]    bankChunkSelect,
    input wire logic [7:0]    dockChunkEn,
    input wire logic [7:0]    exromChunkEn,
    input wire logic          soundWrStb,
    input wire logic          soundRdStb,
    input wire logic          printerWrStb,
    input wire logic          printerRdStb
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Irq timing helpers
    logic        prevIrqQ;
    logic        seenQ;
    logic [19:0] sinceFellQ;
    logic [15:0] lowCntQ;

    always_ff @(posedge mclk) begin
        prevIrqQ <= frameIrqN;
        lowCntQ  <= frameIrqN ? 16'h0 : lowCntQ + 16'h1;
    end

    // Period trusted after a full enabled frame
    always_ff @(posedge mclk) begin
        if (prevIrqQ && !frameIrqN)
            sinceFellQ <= 20'h1;
        else
            sinceFellQ <= sinceFellQ + 20'h1;
        if (rst || displayCtrl.irqInhibit)
            seenQ <= 1'b0;
        else if (prevIrqQ && !frameIrqN)
            seenQ <= 1'b1;
    end

    // ==========================================================
    // Properties
    snd_wr_pulse_a: assert property (soundWrStb |=> !soundWrStb)
        else $error("sound write strobe too wide");
    snd_rd_pulse_a: assert property (soundRdStb |=> !soundRdStb)
        else $error("sound read strobe too wide");
    prn_wr_pulse_a: assert property (printerWrStb |=> !printerWrStb)
        else $error("printer write strobe too wide");
    prn_rd_pulse_a: assert property (printerRdStb |=> !printerRdStb)
        else $error("printer read strobe too wide");
    dock_chunk_a: assert property (dockChunkEn ==
        ($past(displayCtrl.exromSel) ? 8'h00 : $past(bankChunkSelect)))
        else $error("dock enables wrong");
    extension_rom_select_chunk_a: assert property (exromChunkEn ==
        ($past(displayCtrl.exromSel) ? $past(bankChunkSelect) : 8'h00))
        else $error("extension_rom_select enables wrong");
    irq_inhibit_a: assert property (displayCtrl.irqInhibit &&
        $past(displayCtrl.irqInhibit) |-> frameIrqN)
        else $error("irq while inhibited");
    irq_width_a: assert property ($rose(frameIrqN) &&
        !displayCtrl.irqInhibit |-> lowCntQ == 16'(IRQ_PULSE_CYCLES))
        else $error("irq width wrong");
    irq_period_a: assert property ($fell(frameIrqN) && seenQ
        |-> int'(sinceFellQ) == FRAME_CYCLES)
        else $error("irq period wrong");
    read_cause_a: assert property (cpuDataOe |->
        !$past(rdN, 2) || !$past(rdN, 3) || !$past(rdN, 4))
        else $error("data driven without read");
endmodule : io_port_regs_checker

bind io_port_regs io_port_regs_checker #(.FRAME_CYCLES(FRAME_CYCLES)) chk_i (
    .mclk(mclk), .rst(rst), .rdN(rdN), .cpuDataOe(cpuDataOe),
    .frameIrqN(frameIrqN), .displayCtrl(displayCtrl),
    .bankChunkSelect(bankChunkSelect), .dockChunkEn(dockChunkEn),
    .exromChunkEn(exromChunkEn), .soundWrStb(soundWrStb),
    .soundRdStb(soundRdStb), .printerWrStb(printerWrStb),
    .printerRdStb(printerRdStb));

/* File: dv/cpu_io_model.sv */
`timescale 1ns/100ps
module cpu_io_model (
    // Clock
    input wire logic        mclk,
    // Processor I/O cycle
    output logic     [15:0] cpuAddr,
    output logic     [7:0]  cpuDataIn,
    output logic            ioReqN,
    output logic            rdN,
    output logic            wrN,
    input wire logic [7:0]  cpuDataOut,
    input wire logic        cpuDataOe
);
    initial begin
        cpuAddr   = 16'h0000;
        cpuDataIn = 8'h00;
        ioReqN    = 1'b1;
        rdN       = 1'b1;
        wrN       = 1'b1;
    end

    // Released lines flip so stale values cannot pass for live ones
    task automatic idle(input int n);
        ioReqN    <= 1'b1;
        rdN       <= 1'b1;
        wrN       <= 1'b1;
        cpuAddr   <= ~cpuAddr;
        cpuDataIn <= ~cpuDataIn;
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpuAddr   <= a;
        cpuDataIn <= d;
        ioReqN    <= 1'b0;
        wrN       <= 1'b0;
        repeat (4) @(posedge mclk);
        idle(5);
    endtask : io_write

    // Pins held until enable seen high, or timeout
    task automatic io_read(input logic [15:0] a, output logic [7:0] d,
                           output logic oe);
        oe = 1'b0;
        d  = 8'h00;
        @(posedge mclk);
        cpuAddr <= a;
        ioReqN  <= 1'b0;
        rdN     <= 1'b0;
        for (int n = 0; n < 8 && !oe; n++) begin
            @(posedge mclk);
            if (cpuDataOe === 1'b1) begin
                oe = 1'b1;
                d  = cpuDataOut;
            end
        end
        idle(6);
    endtask : io_read
endmodule : cpu_io_model

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
    import io_port_pkg::*;
    localparam int FRAME   = 400;
    localparam int CEILING = 20000;

    logic            mclk, rst, ioReqN, rdN, wrN, tapeIn, cpuDataOe;
    logic            frameIrqN, tapeOut, beepOut, soundWrStb, soundRdStb;
    logic            printerWrStb, printerRdStb, printerSlow;
    logic            printerMotorOff, printerPixel, oe;
    logic [15:0]     cpuAddr;
    logic [39:0]     keyPressed;
    logic [7:0]      cpuDataIn, cpuDataOut, soundRdData, bankChunkSelect;
    logic [7:0]      dockChunkEn, exromChunkEn, soundAddr, soundWrData, rd;
    colour_t         borderColour;
    display_ctrl_t   displayCtrl;
    printer_status_t printerStatus;
    int              errCount, samplesChecked, cycles;

    always #25 mclk = ~mclk;

    cpu_io_model cpu_io_model_i (.mclk(mclk), .cpuAddr(cpuAddr),
        .cpuDataIn(cpuDataIn), .ioReqN(ioReqN), .rdN(rdN), .wrN(wrN),
        .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe));

    io_port_regs #(.FRAME_CYCLES(FRAME)) io_port_regs_i (.mclk(mclk),
        .rst(rst), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn),
        .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe), .ioReqN(ioReqN),
        .rdN(rdN), .wrN(wrN), .frameIrqN(frameIrqN),
        .keyPressed(keyPressed), .tapeIn(tapeIn),
        .borderColour(borderColour), .tapeOut(tapeOut), .beepOut(beepOut),
        .displayCtrl(displayCtrl), .bankChunkSelect(bankChunkSelect),
        .dockChunkEn(dockChunkEn), .exromChunkEn(exromChunkEn),
        .soundAddr(soundAddr), .soundWrData(soundWrData),
        .soundWrStb(soundWrStb), .soundRdStb(soundRdStb),
        .soundRdData(soundRdData), .printerWrStb(printerWrStb),
        .printerRdStb(printerRdStb), .printerSlow(printerSlow),
        .printerMotorOff(printerMotorOff), .printerPixel(printerPixel),
        .printerStatus(printerStatus));

    // ==========================================================
    // Expectations and comparisons
    function automatic logic [7:0] kt_exp(logic [39:0] k, logic [7:0] rowN,
                                          logic t);
        logic [4:0] c;
        c = 5'h1f;
        for (int r = 0; r < 8; r++)
            for (int j = 0; j < 5; j++)
                if (!rowN[r] && k[r*5+j]) c[j] = 1'b0;
        return {1'b0, t, 1'b0, c};
    endfunction : kt_exp

    task automatic chk8(input string n, input logic [7:0] e, g);
        samplesChecked++;
        if (g !== e) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic rd_chk(string n, logic [15:0] a, logic ex, logic [7:0] e);
        cpu_io_model_i.io_read(a, rd, oe);
        chk8({n, " oe"}, {7'h0, ex}, {7'h0, oe});
        if (ex) chk8(n, e, rd);
    endtask : rd_chk

    task automatic end_of_test;
        if (errCount == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    always @(posedge mclk) begin
        cycles++;
        if (cycles >= CEILING) begin
            errCount++;
            end_of_test;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        video_mode_t   modes[4];
        logic [39:0]   k;
        logic [7:0]    rowN, d, a8;
        logic          t;
        int            lows;
        display_ctrl_t keep;
        modes = '{VM_NORMAL, VM_SECOND, VM_HIRES, VM_COL64};
        void'($urandom(32'hab277112));
        mclk = 1'b0;
        rst = 1'b1;
        keyPressed = '0;
        tapeIn = 1'b0;
        soundRdData = 8'h00;
        printerStatus = '0;
        errCount = 0;
        samplesChecked = 0;
        cycles = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk8("display reset", 8'h00, displayCtrl);
        rd_chk("bank reset", 16'h00f4, 1'b1, 8'h00);
        rd_chk("display read", 16'h00ff, 1'b1, 8'h00);
        // Two enabled frames feed the period check
        lows = 0;
        repeat (2 * FRAME + 20) begin
            @(posedge mclk);
            if (frameIrqN === 1'b0) lows++;
        end
        chk8("irq enabled", 8'h01, {7'h0, lows > 0});
        foreach (modes[i]) begin
            d = {1'($urandom), 1'b1, 3'($urandom), modes[i]};
            cpu_io_model_i.io_write(16'h00ff, d);
            chk8("display", d, displayCtrl);
            rd_chk("display read", {8'($urandom), 8'hff}, 1'b1, d);
        end
        lows = 0;
        repeat (FRAME + 20) begin
            @(posedge mclk);
            if (frameIrqN !== 1'b1) lows++;
        end
        chk8("irq inhibited", 8'h00, {7'h0, lows > 0});
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            cpu_io_model_i.io_write(16'h00ff, {i[0], 7'h40});
            cpu_io_model_i.io_write(16'h00f4, d);
            chk8("bank", d, bankChunkSelect);
            chk8("dock", i[0] ? 8'h00 : d, dockChunkEn);
            chk8("extension_rom_select", i[0] ? d : 8'h00, exromChunkEn);
            rd_chk("bank read", 16'h00f4, 1'b1, d);
        end
        cpu_io_model_i.io_write(16'h00f4, 8'h00);
        chk8("home dock", 8'h00, dockChunkEn);
        chk8("home extension_rom_select", 8'h00, exromChunkEn);
        for (int i = 0; i < 8; i++) begin
            d = {3'($urandom), 2'($urandom), i[2:0]};
            cpu_io_model_i.io_write({8'($urandom), 8'hfe}, d);
            chk8("border", {5'h0, i[2:0]}, {5'h0, borderColour});
            chk8("tape out", {7'h0, d[3]}, {7'h0, tapeOut});
            chk8("beep", {7'h0, d[4]}, {7'h0, beepOut});
        end
        // All rows, no row, random rows
        for (int i = 0; i < 12; i++) begin
            k = {8'($urandom), $urandom};
            t = 1'($urandom);
            rowN = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            keyPressed <= k;
            tapeIn <= t;
            @(posedge mclk);
            rd_chk("keys", {rowN, 8'hfe}, 1'b1, kt_exp(k, rowN, t));
        end
        d = 8'($urandom);
        cpu_io_model_i.io_write(16'h00f5, d);
        chk8("sound addr", d, soundAddr);
        d = 8'($urandom);
        cpu_io_model_i.io_write(16'h00f6, d);
        chk8("sound data", d, soundWrData);
        d = 8'($urandom);
        soundRdData <= d;
        rd_chk("joystick", 16'h00f6, 1'b1, d);
        rd_chk("sound addr read", 16'h00f5, 1'b0, 8'h00);
        for (int i = 0; i < 6; i++) begin
            a8 = (8'($urandom) & 8'hfb) | 8'h80;
            d = 8'($urandom);
            cpu_io_model_i.io_write({8'($urandom), a8}, d);
            chk8("prn slow", {7'h0, d[1]}, {7'h0, printerSlow});
            chk8("prn motor", {7'h0, d[2]}, {7'h0, printerMotorOff});
            chk8("prn pixel", {7'h0, d[7]}, {7'h0, printerPixel});
            printerStatus <= 3'($urandom);
            @(posedge mclk);
            rd_chk("prn status", {8'($urandom), a8}, 1'b1,
                {printerStatus.startOfPaper, printerStatus.notConfigured,
                 5'h0, printerStatus.readyForPixel});
        end
        rd_chk("reserved fd", 16'h00fd, 1'b0, 8'h00);
        rd_chk("reserved fc", 16'h00fc, 1'b0, 8'h00);
        rd_chk("unmapped", 16'h007f, 1'b0, 8'h00);
        keep = displayCtrl;
        cpu_io_model_i.io_write(16'h00fd, 8'($urandom));
        cpu_io_model_i.io_write(16'h00fc, 8'($urandom));
        chk8("display kept", keep, displayCtrl);
        chk8("bank kept", 8'h00, bankChunkSelect);
        end_of_test;
    end
endmodule : tb
